/* pkg/hsar_pkg.sv */
package hsar_pkg;
	// ==========================================================
	// Bus addresses and codes
	localparam logic [4:0] HSAR_HS_CODE_TOP     = 5'h01;
	localparam logic [6:0] HSAR_ALERT_RESP_ADDR = 7'h0C;
	localparam logic [4:0] HSAR_BASE_ADDR_TOP   = 5'h10;
	// ==========================================================
	// Reset values and counts
	localparam logic [3:0] HSAR_BIT_LAST        = 4'h7;
	localparam logic [3:0] HSAR_BIT_ACK         = 4'h8;
	localparam logic [3:0] HSAR_BITCNT_RST      = 4'h0;
	localparam logic       HSAR_HS_RST          = 1'b0;
	localparam logic       HSAR_ALERT_RST       = 1'b0;
	// ==========================================================
	// Link states
	typedef enum logic [5:0] {
		HSAR_IDLE  = 6'h01,
		HSAR_ADDR  = 6'h02,
		HSAR_AACK  = 6'h04,
		HSAR_TX    = 6'h08,
		HSAR_RACK  = 6'h10,
		HSAR_IGN   = 6'h20
	} hsar_state_t;
endpackage

/* hw/hsar_slave.sv */
`timescale 1ns/1ps
// Behaviour
// - Master code byte is never acknowledged; SDA stays released in ninth clock.
// - Recognised master code switches input filtering to high-speed setting.
// - After master code a repeated start; normal protocol continues at higher clock.
// - A stop condition exits high-speed mode and restores standard filtering.
// - Alert Response address with read bit is recognised only while alert is pending; own address is never acknowledged.
// - With alert pending, acknowledge Alert Response then send own address byte.
// - Follow arbitration; on loss stop driving, no acknowledge, keep alert asserted.
// - Own address comes from select pin, sampled each transaction, four choices.
module hsar_slave
	import hsar_pkg::*;
(
	input  wire logic       clk_sys,
	input  wire logic       rst,
	input  wire logic       scl_clk,
	input  wire logic       sda_in,
	output logic            sda_out,
	output logic            sda_oe_n,
	input  wire logic [1:0] address_select_pin,
	input  wire logic       alert_pending,
	input  wire logic       alert_clear,
	output logic            alert_n,
	output logic            hs_filter_en
);
	// ==========================================================
	// Link domain state, clocked by the bus clock itself
	typedef struct packed {
		hsar_state_t st;
		logic [3:0]  bitcnt;
		logic [7:0]  shreg;
		logic [7:0]  txbyte;
		logic        hs;
		logic        arb_lost;
		logic [1:0]  sel;
	} hsar_link_t;

	hsar_link_t link_reg;
	hsar_link_t link_next;

	// Start and stop are SDA edges while SCL is high; sampled on SDA edges
	logic start_tgl_reg;
	logic stop_tgl_reg;
	logic start_seen_reg;
	logic stop_seen_reg;

	always_ff @(negedge sda_in or posedge rst) begin
		if (rst) begin
			start_tgl_reg <= 1'b0;
		end else if (scl_clk) begin
			start_tgl_reg <= ~start_tgl_reg;
		end
	end

	always_ff @(posedge sda_in or posedge rst) begin
		if (rst) begin
			stop_tgl_reg <= 1'b0;
		end else if (scl_clk) begin
			stop_tgl_reg <= ~stop_tgl_reg;
		end
	end

	// Toggles compared on the next SCL rise mark a condition seen before it
	logic start_ack_reg;
	logic stop_ack_reg;

	always_ff @(posedge scl_clk or posedge rst) begin
		if (rst) begin
			start_ack_reg <= 1'b0;
			stop_ack_reg  <= 1'b0;
		end else begin
			start_ack_reg <= start_tgl_reg;
			stop_ack_reg  <= stop_tgl_reg;
		end
	end

	always_comb begin
		start_seen_reg = start_tgl_reg != start_ack_reg;
		stop_seen_reg  = stop_tgl_reg != stop_ack_reg;
	end

	// ==========================================================
	// Alert level crosses into the link domain through two flops
	logic       alert_hold_reg;
	logic       drive_reg;
	logic       hs_live;
	logic [1:0] alert_sync_reg;
	logic [1:0] sel_sync_reg;
	logic [1:0] sel_sync2_reg;

	always_ff @(posedge scl_clk or posedge rst) begin
		if (rst) begin
			alert_sync_reg <= 2'h0;
			sel_sync_reg   <= 2'h0;
			sel_sync2_reg  <= 2'h0;
		end else begin
			alert_sync_reg <= {alert_sync_reg[0], alert_hold_reg};
			sel_sync_reg   <= address_select_pin;
			sel_sync2_reg  <= sel_sync_reg;
		end
	end

	function automatic logic [6:0] hsar_own_addr(input logic [1:0] sel);
		hsar_own_addr = {HSAR_BASE_ADDR_TOP, sel};
	endfunction

	// Bit counting on SCL rise; state advances on rise
	always_comb begin
		link_next = link_reg;
		if (start_seen_reg) begin
			link_next.st       = HSAR_ADDR;
			link_next.bitcnt   = 4'h1;
			link_next.shreg    = {7'h00, sda_in};
			link_next.arb_lost = 1'b0;
			link_next.sel      = sel_sync2_reg;
			// Stop and start inside one SCL high phase: the stop still ends high-speed mode
			if (stop_seen_reg) begin
				link_next.hs = 1'b0;
			end
		end else if (stop_seen_reg) begin
			link_next.st = HSAR_IDLE;
			link_next.hs = 1'b0;
		end else begin
			case (link_reg.st)
				HSAR_IDLE: begin
				end
				HSAR_ADDR: begin
					link_next.shreg  = {link_reg.shreg[6:0], sda_in};
					link_next.bitcnt = link_reg.bitcnt + 4'h1;
					if (link_reg.bitcnt == HSAR_BIT_LAST) begin
						if (link_next.shreg[7:3] == HSAR_HS_CODE_TOP) begin
							link_next.hs = 1'b1;
							link_next.st = HSAR_IGN;
						end else if (link_next.shreg == {HSAR_ALERT_RESP_ADDR, 1'b1}
							&& alert_sync_reg[1]) begin
							link_next.st     = HSAR_AACK;
							link_next.txbyte = {hsar_own_addr(link_reg.sel), 1'b0};
						end else begin
							link_next.st = HSAR_IGN;
						end
					end
				end
				HSAR_AACK: begin
					link_next.st     = HSAR_TX;
					link_next.bitcnt = HSAR_BITCNT_RST;
				end
				HSAR_TX: begin
					if (!drive_reg && !sda_in) begin
						link_next.arb_lost = 1'b1;
						link_next.st       = HSAR_IGN;
					end else begin
						link_next.bitcnt = link_reg.bitcnt + 4'h1;
						if (link_reg.bitcnt == HSAR_BIT_LAST) begin
							link_next.st = HSAR_RACK;
						end
					end
				end
				HSAR_RACK: begin
					link_next.st = HSAR_IGN;
				end
				HSAR_IGN: begin
				end
				default: begin
					link_next.st = HSAR_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge scl_clk or posedge rst) begin
		if (rst) begin
			link_reg <= '{st: HSAR_IDLE, bitcnt: HSAR_BITCNT_RST, shreg: 8'h00,
				txbyte: 8'h00, hs: HSAR_HS_RST, arb_lost: 1'b0,
				sel: 2'h0};
		end else begin
			link_reg <= link_next;
		end
	end

	// SDA changes on SCL fall so it is stable while SCL is high
	logic [3:0] txidx;

	always_comb begin
		txidx = HSAR_BIT_LAST - link_reg.bitcnt;
	end

	always_ff @(negedge scl_clk or posedge rst) begin
		if (rst) begin
			drive_reg <= 1'b0;
		end else if (link_reg.st == HSAR_AACK) begin
			drive_reg <= 1'b1;
		end else if (link_reg.st == HSAR_TX && !link_reg.arb_lost) begin
			drive_reg <= ~link_reg.txbyte[txidx[2:0]];
		end else begin
			drive_reg <= 1'b0;
		end
	end

	always_comb begin
		sda_out  = 1'b0;
		sda_oe_n = ~drive_reg;
	end

	// ==========================================================
	// System domain: alert is held until software clears it
	logic [1:0] hs_sync_reg;

	// A pending stop masks the flag at once; SCL may stay idle for a long time
	always_comb begin
		hs_live = link_reg.hs & ~stop_seen_reg;
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			alert_hold_reg <= HSAR_ALERT_RST;
			hs_sync_reg    <= 2'h0;
		end else begin
			// Set wins over clear so no alert is lost
			alert_hold_reg <= alert_pending | (alert_hold_reg & ~alert_clear);
			hs_sync_reg    <= {hs_sync_reg[0], hs_live};
		end
	end

	always_comb begin
		alert_n      = ~alert_hold_reg;
		hs_filter_en = hs_sync_reg[1];
	end
endmodule

/* sim/hsar_checker.sv */
`timescale 1ns/1ps
module hsar_checker (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic scl_clk,
	input wire logic sda_out,
	input wire logic sda_oe_n,
	input wire logic alert_pending,
	input wire logic alert_clear,
	input wire logic alert_n,
	input wire logic hs_filter_en
);
	// ====================
	// Checks
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	sequence scl_idle; scl_clk [*3]; endsequence
	sequence bus_rest; scl_clk [*5]; endsequence
	out_zero_a: assert property (!sda_oe_n |-> !sda_out && !alert_n) else $error("sda");
	alert_set_a: assert property (alert_pending |=> !alert_n) else $error("no alert");
	alert_hold_a: assert property (!alert_n && !alert_clear |=> !alert_n) else $error("lost");
	alert_clr_a: assert property (alert_clear && !alert_pending |=> alert_n) else $error("kept");
	hs_reset_a: assert property ($fell(rst) |-> !hs_filter_en) else $error("hs on");
	bus_free_a: assert property (scl_idle |-> sda_oe_n) else $error("sda held");
	drive_alert_a: assert property ($fell(sda_oe_n) |-> !alert_n) else $error("stray");
	hs_exit_a: assert property (bus_rest |-> !hs_filter_en) else $error("hs kept");
endmodule
bind hsar_slave hsar_checker chk (.clk_sys, .rst, .scl_clk, .sda_out, .sda_oe_n,
	.alert_pending, .alert_clear, .alert_n, .hs_filter_en);

/* sim/hsar_master.sv */
`timescale 1ns/1ps
module hsar_master (
	output logic      scl,
	output logic      sda_m,
	input  wire logic sda
);
	// ====================
	// Bus master
	logic [8:0] res;
	event       fin;
	initial scl = 1'b1;
	initial sda_m = 1'b1;
	task automatic bitx(input logic b, output logic r);
		sda_m = b;
		#3.5 scl = 1'b1;
		r = sda;
		#7.5 scl = 1'b0;
		#4;
	endtask
	// Flags are read, lose, stop; a lost read pulls SDA low like a rival slave
	task automatic xfer(input logic [7:0] a, input logic [2:0] f);
		logic k;
		#4 scl = 1'b1;
		#4 sda_m = 1'b0;
		#4 scl = 1'b0;
		for (int i = 7; i >= 0; i--) bitx(a[i], k);
		bitx(1'b1, res[8]);
		res[7:0] = 8'h00;
		if (f[2]) begin
			for (int i = 7; i >= 0; i--) bitx(!f[1], res[i]);
			bitx(1'b1, k);
		end
		if (f[0]) sda_m = 1'b0;
		#4 scl = f[0];
		#4 sda_m = 1'b1;
		#200 ->fin;
	endtask
endmodule

/* sim/hsar_slave_tb.sv */
`timescale 1ns/1ps
module hsar_slave_tb;
	import hsar_pkg::*;
	localparam logic [7:0] AR = {HSAR_ALERT_RESP_ADDR, 1'b1};
	logic        clk_sys, rst, scl, sda_m, sda_oe_n, sda_out;
	logic        alert_pending, alert_clear, alert_n, hs_filter_en;
	logic [1:0]  sel;
	logic [10:0] q[$];
	int          miscompares;
	int          total_checks;
	wire         sda = sda_m & (sda_oe_n | sda_out);
	hsar_slave dut (.clk_sys, .rst, .scl_clk(scl), .sda_in(sda), .sda_out, .sda_oe_n,
		.address_select_pin(sel), .alert_pending, .alert_clear, .alert_n, .hs_filter_en);
	hsar_master m (.scl, .sda_m, .sda);
	// ====================
	// Test sequence
	initial begin
		clk_sys = 1'b0;
		forever #20 clk_sys = ~clk_sys;
	end
	task automatic stop_test();
		if (miscompares == 0 && total_checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	initial begin
		repeat (2000) @(posedge clk_sys);
		miscompares++;
		stop_test();
	end
	always @(m.fin) begin
		total_checks++;
		if ({alert_n, hs_filter_en, m.res} !== q.pop_front()) begin
			miscompares++;
			$display("[FAIL] %0t bad result", $time);
		end
	end
	task automatic run(input logic [7:0] a, input logic [2:0] f, input logic [10:0] x);
		q.push_back(x);
		m.xfer(a, f);
	endtask
	initial begin
		{rst, alert_pending, alert_clear} = 3'h4;
		sel = 2'($urandom(32'h1D677EA4));
		repeat (2) @(posedge clk_sys);
		#1 rst = 1'b0;
		run(AR, 3'h5, 11'h5FF);
		@(posedge clk_sys) #1 alert_pending = 1'b1;
		@(posedge clk_sys) #1 alert_pending = 1'b0;
		run({HSAR_HS_CODE_TOP, 3'($urandom())}, 3'h0, 11'h300);
		run(AR, 3'h4, {3'h2, HSAR_BASE_ADDR_TOP, sel, 1'b0});
		@(posedge clk_sys) #1 sel = 2'($urandom());
		run({3'h7, 4'($urandom()), 1'b0}, 3'h1, 11'h100);
		run(AR, 3'h4, {3'h0, HSAR_BASE_ADDR_TOP, sel, 1'b0});
		run(AR, 3'h7, 11'h000);
		@(posedge clk_sys) #1 alert_clear = 1'b1;
		@(posedge clk_sys) #1 alert_clear = 1'b0;
		run(AR, 3'h5, 11'h5FF);
		@(posedge clk_sys) stop_test();
	end
endmodule
